// ---- inc/ee_access_pkg.sv ----
package ee_access_pkg;
    localparam int ADDR_W = 5;
    // register word offsets on the bus (byte addresses)
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_UNLOCK = 5'h04;
    localparam logic [ADDR_W-1:0] ADDR_DATA = 5'h08;
    localparam logic [ADDR_W-1:0] ADDR_ADDRESS = 5'h0c;
    localparam logic [ADDR_W-1:0] ADDR_FLAGS = 5'h10;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 5'h14;
    localparam logic [ADDR_W-1:0] ADDR_RESET_CAUSE = 5'h18;
    // control register bit positions
    localparam int CTL_READ = 0;
    localparam int CTL_STORE = 1;
    localparam int CTL_PERMIT = 2;
    localparam int CTL_ERROR = 3;
    localparam int CTL_W = 4;
    // flag and mask bit positions
    localparam int FLG_DONE = 0;
    localparam int FLG_W = 1;
    // reset cause bits (write-one pulses from the reset controller)
    localparam int CAUSE_POWER = 0;
    localparam int CAUSE_PIN = 1;
    localparam int CAUSE_WDOG = 2;
    localparam int CAUSE_BROWN = 3;
    // unlock sequence, arbitrary values
    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
    // array write time
    localparam int STORE_TIME_US = 5;
    localparam int CLK_MHZ = 100;
    localparam int STORE_CYCLES = STORE_TIME_US * CLK_MHZ;
    localparam int CNT_W = 16;
    localparam int DEPTH = 256;
endpackage

// ---- design/ee_access_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module ee_access_ctrl
    import ee_access_pkg::*;
#(
    parameter int STORE_COUNT = STORE_CYCLES
) (
    input wire logic clk_i, // core clock
    input wire logic rst_i, // sync reset, high
    input wire logic cyc_i, // wishbone cycle
    input wire logic stb_i, // wishbone strobe
    input wire logic we_i, // wishbone write
    input wire logic [ADDR_W-1:0] adr_i, // byte address
    input wire logic [3:0] sel_i, // byte enables
    input wire logic [31:0] dat_i, // write data
    output logic [31:0] dat_o, // read data
    output logic ack_o, // wishbone ack
    output logic irq_o, // interrupt level
    input wire logic power_rst_i, // power-on reset pulse
    input wire logic pin_rst_i, // master clear pin reset pulse
    input wire logic wdog_rst_i, // watchdog timeout reset pulse
    input wire logic brown_rst_i // brownout reset pulse
);

    typedef enum logic [1:0] {
        IDLE,
        KEY1_OK,
        ARMED
    } unlock_t;

    // whole block state, registered in one place
    typedef struct packed {
        logic [7:0] data;
        logic [7:0] addr;
        logic rd;
        logic wr;
        logic permit;
        logic err;
        logic done;
        logic mask;
        unlock_t lock;
        logic [CNT_W-1:0] cnt;
        logic [31:0] rdata;
        logic ack;
        logic irq;
        logic [DEPTH-1:0][7:0] mem;
    } state_t;

    state_t s_q;
    state_t s_d;

    // address decode, shared by the read and write paths
    function automatic logic at(
        input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] off
    );
        at = a == off;
    endfunction

    // last cycle of a store, when the array takes the byte
    function automatic logic store_ends(input state_t s);
        store_ends = s.wr && s.cnt == CNT_W'(1);
    endfunction

    function automatic logic [31:0] control_word(input state_t s);
        logic [31:0] w;
        w = 32'h0;
        w[CTL_READ] = s.rd;
        w[CTL_STORE] = s.wr;
        w[CTL_PERMIT] = s.permit;
        w[CTL_ERROR] = s.err;
        control_word = w;
    endfunction

    // unmapped offsets fall through and read zero
    function automatic logic [31:0] read_word(
        input state_t s,
        input logic [ADDR_W-1:0] a
    );
        logic [31:0] w;
        w = 32'h0;
        if (at(a, ADDR_CONTROL)) begin
            w = control_word(s);
        end
        if (at(a, ADDR_UNLOCK)) begin
            w = 32'h0;
        end
        if (at(a, ADDR_DATA)) begin
            w[7:0] = s.data;
        end
        if (at(a, ADDR_ADDRESS)) begin
            w[7:0] = s.addr;
        end
        if (at(a, ADDR_FLAGS)) begin
            w[FLG_DONE] = s.done;
        end
        if (at(a, ADDR_MASK)) begin
            w[FLG_DONE] = s.mask;
        end
        read_word = w;
    endfunction

    function automatic unlock_t unlock_step(
        input unlock_t cur,
        input logic [7:0] key
    );
        unlock_t nxt;
        nxt = IDLE;
        unique case (cur)
            IDLE: begin
                if (key == UNLOCK_KEY1) begin
                    nxt = KEY1_OK;
                end
            end
            KEY1_OK: begin
                if (key == UNLOCK_KEY2) begin
                    nxt = ARMED;
                end
            end
            ARMED: begin
                nxt = IDLE;
            end
            default: begin
                nxt = IDLE;
            end
        endcase
        unlock_step = nxt;
    endfunction

    function automatic logic store_allowed(
        input state_t s,
        input logic [31:0] wdat
    );
        store_allowed = wdat[CTL_STORE] && wdat[CTL_PERMIT] &&
                        s.permit && !s.wr && s.lock == ARMED;
    endfunction

    // state after the bus reset; the array keeps its content
    function automatic state_t reset_image(input state_t s);
        state_t r;
        r = s;
        r.data = 8'h0;
        r.addr = 8'h0;
        r.rd = 1'b0;
        r.wr = 1'b0;
        r.permit = 1'b0;
        r.err = 1'b0;
        r.done = 1'b0;
        r.mask = 1'b0;
        r.lock = IDLE;
        r.cnt = '0;
        r.rdata = 32'h0;
        r.ack = 1'b0;
        r.irq = 1'b0;
        reset_image = r;
    endfunction

    // bus request qualifiers
    logic req;
    logic wr_lane;
    logic rd_req;
    logic abort_rst;
    logic any_rst;
    logic [7:0] wr_byte;

    assign req = cyc_i && stb_i && !s_q.ack;
    assign wr_lane = req && we_i && sel_i[0];
    assign rd_req = req && !we_i;
    assign wr_byte = dat_i[7:0];
    // power-on is not counted as cutting a store short
    assign abort_rst = pin_rst_i || wdog_rst_i || brown_rst_i;
    assign any_rst = power_rst_i || abort_rst;

    always_comb begin
        s_d = s_q;
        // one-cycle ack; a standing ack masks the request
        s_d.ack = req;
        s_d.rdata = 32'h0;

        if (s_q.rd) begin
            s_d.data = s_q.mem[s_q.addr];
            s_d.rd = 1'b0;
        end

        // store countdown; the array takes the byte on the last cycle
        if (s_q.wr) begin
            s_d.cnt = s_q.cnt - CNT_W'(1);
        end
        if (store_ends(s_q)) begin
            s_d.mem[s_q.addr] = s_q.data;
            s_d.wr = 1'b0;
            s_d.done = 1'b1;
        end

        if (rd_req) begin
            s_d.rdata = read_word(s_q, adr_i);
        end

        if (wr_lane && at(adr_i, ADDR_CONTROL)) begin
            // permit follows the bit; a store needs it old and new
            s_d.permit = dat_i[CTL_PERMIT];
            if (!dat_i[CTL_ERROR]) begin
                s_d.err = 1'b0;
            end
            // no array read starts while a store owns it
            // set-only triggers
            if (dat_i[CTL_READ] && !s_q.wr) begin
                s_d.rd = 1'b1;
            end
            if (store_allowed(s_q, dat_i)) begin
                s_d.wr = 1'b1;
                s_d.cnt = CNT_W'(STORE_COUNT);
            end
        end

        // any write other than the next key breaks the sequence
        if (wr_lane) begin
            if (at(adr_i, ADDR_UNLOCK)) begin
                s_d.lock = unlock_step(s_q.lock, wr_byte);
            end else begin
                s_d.lock = IDLE;
            end
        end

        // trusted: data and address change freely
        if (wr_lane && at(adr_i, ADDR_DATA)) begin
            s_d.data = wr_byte;
        end

        if (wr_lane && at(adr_i, ADDR_ADDRESS)) begin
            s_d.addr = wr_byte;
        end

        if (wr_lane && at(adr_i, ADDR_MASK)) begin
            s_d.mask = dat_i[FLG_DONE];
        end

        // write-one-to-clear; a completing store in this cycle wins
        if (wr_lane && at(adr_i, ADDR_FLAGS) && dat_i[FLG_DONE] &&
            !store_ends(s_q)) begin
            s_d.done = 1'b0;
        end

        // system reset events abort any access in flight short of its last cycle
        if (any_rst) begin
            if (abort_rst && s_q.wr && !store_ends(s_q)) begin
                s_d.err = 1'b1;
                s_d.data = 8'h0;
                s_d.addr = 8'h0;
            end
            s_d.wr = 1'b0;
            s_d.rd = 1'b0;
            s_d.permit = 1'b0;
            s_d.lock = IDLE;
            s_d.cnt = '0;
        end
        if (power_rst_i) begin
            s_d.permit = 1'b0;
        end

        // level interrupt while the flag is set and unmasked
        s_d.irq = s_d.done && s_d.mask;
    end

    // synchronous bus reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= reset_image(s_q);
        end else begin
            s_q <= s_d;
        end
    end

    assign dat_o = s_q.rdata;
    assign ack_o = s_q.ack;
    assign irq_o = s_q.irq;
endmodule
`default_nettype wire

// ---- tb/ee_access_ctrl_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module ee_access_chk
    import ee_access_pkg::*;
(
    input wire logic clk_i, // clock
    input wire logic rst_i, // reset
    input wire logic cyc_i, // cycle
    input wire logic stb_i, // strobe
    input wire logic we_i, // write
    input wire logic [ADDR_W-1:0] adr_i, // address
    input wire logic [31:0] dat_i, // write data
    input wire logic [31:0] dat_o, // read data
    input wire logic ack_o, // ack
    input wire logic irq_o // interrupt
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic rd_c = ack_o && !we_i && adr_i == 5'(ADDR_CONTROL);
    a_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack missing after request");
    a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack held");
    a_ack_caused: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    a_ctl_upper: assert property (rd_c |-> dat_o[31:4] == 0)
        else $error("control upper bits set");
    a_read_clears: assert property (rd_c |-> !dat_o[CTL_READ])
        else $error("read trigger still set");
    a_unlock_zero: assert property (ack_o && !we_i &&
        adr_i == 5'(ADDR_UNLOCK) |-> dat_o == 0) else $error("unlock reads");
    a_unmapped_zero: assert property (ack_o && !we_i && adr_i == 5'h18
        |-> dat_o == 0) else $error("unmapped read not zero");
    // irq is registered with the mask, so it is low in the ack cycle
    a_irq_masked: assert property (ack_o && we_i && adr_i == 5'h14 &&
        !dat_i[0] |-> !irq_o) else $error("masked irq high");
endmodule
bind ee_access_ctrl ee_access_chk u_chk (.clk_i, .rst_i, .cyc_i, .stb_i,
    .we_i, .adr_i, .dat_i, .dat_o, .ack_o, .irq_o);
`default_nettype wire

// ---- tb/test_ee_access_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("BAD %0s exp %h got %h", n, e, g); end end
module test_ee_access_ctrl
    import ee_access_pkg::*;
;
    localparam logic [4:0] A_FLG = 5'h10;
    localparam logic [4:0] A_MSK = 5'h14;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [4:0] adr_i = 0;
    logic [31:0] dat_i = 0, dat_o, q;
    logic ack_o, irq_o;
    logic [3:0] ev = 0;
    int failures = 0, n_tests = 0, cyc_n = 0;
    always #5 clk_i = ~clk_i;
    ee_access_ctrl #(.STORE_COUNT(40)) DUT (.clk_i, .rst_i, .cyc_i, .stb_i,
        .we_i, .adr_i, .sel_i(4'hf), .dat_i, .dat_o, .ack_o, .irq_o,
        .power_rst_i(ev[0]), .pin_rst_i(ev[1]), .wdog_rst_i(ev[2]),
        .brown_rst_i(ev[3]));
    task automatic report_and_stop;
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h0, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        `CHK($sformatf("reg %h", a), {24'h0, e}, q)
    endtask
    task automatic unl;
        wr(ADDR_UNLOCK, UNLOCK_KEY1);
        wr(ADDR_UNLOCK, UNLOCK_KEY2);
    endtask
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 3000) begin
            failures++;
            report_and_stop();
        end
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(ADDR_CONTROL, 8'h00);
        wr(A_MSK, 8'h01);
        unl();
        wr(ADDR_CONTROL, 8'h06);
        rd(ADDR_CONTROL, 8'h04);
        wr(ADDR_ADDRESS, 8'h03);
        wr(ADDR_DATA, 8'ha5);
        wr(ADDR_CONTROL, 8'h04);
        wr(ADDR_CONTROL, 8'h06);
        rd(ADDR_CONTROL, 8'h04);
        unl();
        wr(ADDR_CONTROL, 8'h06);
        wr(ADDR_CONTROL, 8'h04);
        rd(ADDR_CONTROL, 8'h06);
        repeat (50) @(posedge clk_i);
        rd(ADDR_CONTROL, 8'h04);
        rd(A_FLG, 8'h01);
        `CHK("irq", 1'b1, irq_o)
        wr(A_MSK, 8'h00);
        @(posedge clk_i);
        `CHK("irq", 1'b0, irq_o)
        wr(A_FLG, 8'h01);
        rd(A_FLG, 8'h00);
        wr(ADDR_DATA, 8'h00);
        wr(ADDR_CONTROL, 8'h05);
        rd(ADDR_DATA, 8'ha5);
        rd(ADDR_CONTROL, 8'h04);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_DATA, 8'h5a);
            wr(ADDR_CONTROL, 8'h04);
            unl();
            wr(ADDR_CONTROL, 8'h06);
            ev <= 4'h1 << i;
            @(posedge clk_i);
            ev <= 4'h0;
            @(posedge clk_i);
            // power pulse drops permit but raises no error
            rd(ADDR_CONTROL, (i > 0) ? 8'h08 : 8'h00);
            rd(ADDR_DATA, (i > 0) ? 8'h00 : 8'h5a);
            wr(ADDR_CONTROL, 8'h00);
            rd(ADDR_CONTROL, 8'h00);
        end
        rd(ADDR_UNLOCK, 8'h00);
        wr(5'h18, 8'hff);
        rd(5'h18, 8'h00);
        report_and_stop();
    end
endmodule
`default_nettype wire
